// [idw_source.sv]
// Identify parameter-word source with AXI4-Lite configuration
//
// Chosen here: register access over AXI4-Lite and the address map.
`default_nettype none
module idw_source #(
    parameter logic [15:0] DEF_CYL = 16'h03D4,
    parameter logic [15:0] DEF_HEAD = 16'h0010,
    parameter logic [15:0] DEF_SPT = 16'h0020,
    parameter logic [31:0] DEF_CARD = 32'h0007A800,
    parameter logic [15:0] MAJOR_VER = 16'h0000,
    parameter logic [63:0] FW_TEXT = "REV 1.00",
    parameter logic [319:0] MODEL_TEXT = "GENERIC FLASH CARD",
    parameter int MODEL_LEN = 18,
    parameter logic [159:0] SERIAL_TEXT = "000000001",
    parameter int SERIAL_LEN = 9
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Command side
    input wire logic start_in,
    input wire logic start_dma_in,
    input wire logic rd_strobe_in,
    output logic drq_out,
    output logic dmarq_out,
    output logic [15:0] data_out,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////

    idw_pkg::idw_cfg_s cfg;
    idw_pkg::idw_geom_s geom;
    logic [31:0] card_sectors;
    logic [15:0] apm_val;
    logic [15:0] erase_time;
    logic [31:0] capacity;
    logic [7:0] word_idx;
    logic busy;
    logic dma_xfer;
    logic [4:0] gap_cnt;
    logic hold;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [15:0] next_word;
    logic [7:0] next_idx;

    // Byte of a padded ASCII field; text sits in the low bytes
    function automatic logic [7:0] text_byte(input logic [319:0] text, input int len,
                                             input int pos, input int width,
                                             input logic right);
        int k;
        k = right ? pos - (width - len) : pos;
        if (k < 0 || k >= len) begin
            text_byte = 8'h20;
        end else begin
            text_byte = text[8 * (len - 1 - k) +: 8];
        end
    endfunction

    function automatic logic [15:0] text_word(input logic [319:0] text, input int len,
                                              input int w, input int width,
                                              input logic right);
        text_word = {text_byte(text, len, 2 * w, width, right),
                     text_byte(text, len, 2 * w + 1, width, right)};
    endfunction

////////////////////////////////////////////////////////////////////////////////

    // Parameter word lookup; unnamed words fall through to zero
    function automatic logic [15:0] word_at(input logic [7:0] i);
        word_at = 16'h0000;
        case (i)
            8'h00: word_at = idw_pkg::W_GENCFG;
            8'h01: word_at = geom.cyl;
            8'h03: word_at = geom.head;
            8'h06: word_at = geom.spt;
            8'h07: word_at = card_sectors[31:16];
            8'h08: word_at = card_sectors[15:0];
            8'h14: word_at = idw_pkg::W_BUFTYPE;
            8'h15: word_at = idw_pkg::W_BUFSIZE;
            8'h16: word_at = idw_pkg::W_ECC;
            8'h2F: word_at = idw_pkg::W_MAXMULT;
            8'h30: word_at = 16'h0000;
            8'h31: begin
                word_at = idw_pkg::W_CAP_LBA | (cfg.dma_en ? idw_pkg::W_CAP_DMA : 16'h0000);
                if (!cfg.dma_en) begin
                    word_at = idw_pkg::W_CAP_DMA;
                end
            end
            8'h33: word_at = {6'h00, cfg.pio_mode, 8'h00};
            8'h34: word_at = 16'h0000;
            8'h35: word_at = idw_pkg::W_VALID;
            8'h36: word_at = geom.cyl;
            8'h37: word_at = geom.head;
            8'h38: word_at = geom.spt;
            8'h39: word_at = capacity[15:0];
            8'h3A: word_at = capacity[31:16];
            8'h3B: word_at = {idw_pkg::W_MULT_VALID, 7'h00, cfg.mult_one};
            8'h3C: word_at = card_sectors[15:0];
            8'h3D: word_at = card_sectors[31:16];
            8'h3F: word_at = cfg.dma_en ? idw_pkg::W_MWDMA : 16'h0000;
            8'h40: word_at = idw_pkg::W_ADVPIO;
            8'h41: word_at = cfg.dma_en ? idw_pkg::W_CYCLE_NS : 16'h0000;
            8'h42: word_at = cfg.dma_en ? idw_pkg::W_CYCLE_NS : 16'h0000;
            8'h43: word_at = idw_pkg::W_CYCLE_NS;
            8'h44: word_at = idw_pkg::W_CYCLE_NS;
            8'h50: word_at = MAJOR_VER;
            8'h53: word_at = idw_pkg::W_FEAT83;
            8'h54: word_at = idw_pkg::W_FEAT84;
            8'h56: word_at = idw_pkg::W_FEAT86;
            8'h57: word_at = idw_pkg::W_FEAT87;
            8'h58: word_at = 16'h0000;
            8'h59: word_at = erase_time;
            8'h5B: word_at = apm_val;
            8'hA4: word_at = idw_pkg::W_ADV164;
            default: begin
                if (i >= 8'h0A && i <= 8'h13) begin
                    word_at = text_word({160'h0, SERIAL_TEXT}, SERIAL_LEN,
                                        int'(i) - 10, 20, 1'b1);
                end else if (i >= 8'h17 && i <= 8'h1A) begin
                    word_at = text_word({256'h0, FW_TEXT}, 8, int'(i) - 23, 8, 1'b0);
                end else if (i >= 8'h1B && i <= 8'h2E) begin
                    word_at = text_word(MODEL_TEXT, MODEL_LEN,
                                        int'(i) - 27, 40, 1'b0);
                end
            end
        endcase
    endfunction

////////////////////////////////////////////////////////////////////////////////

    // Word stream, same request handshake as a one-sector read
    always_comb begin
        next_idx = word_idx;
        if (start_in) begin
            next_idx = 8'h00;
        end else if (busy && rd_strobe_in) begin
            next_idx = word_idx + 8'h01;
        end
        next_word = word_at(next_idx);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            word_idx <= 8'h00;
            busy <= 1'b0;
            drq_out <= 1'b0;
            dma_xfer <= 1'b0;
            data_out <= 16'h0000;
        end else begin
            word_idx <= next_idx;
            data_out <= next_word;
            if (start_in) begin
                busy <= 1'b1;
                drq_out <= 1'b1;
                dma_xfer <= start_dma_in && cfg.dma_en;
            end else if (busy && rd_strobe_in && word_idx == 8'hFF) begin
                busy <= 1'b0;
                drq_out <= 1'b0;
                dma_xfer <= 1'b0;
            end
        end
    end

    // Pacing: a read sooner than the recommended cycle holds off the request
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            gap_cnt <= 5'h00;
            hold <= 1'b0;
            dmarq_out <= 1'b0;
        end else begin
            if (start_in || rd_strobe_in) begin
                gap_cnt <= 5'h00;
            end else if (gap_cnt < 5'(idw_pkg::REC_CYC)) begin
                gap_cnt <= gap_cnt + 5'h01;
            end
            if (rd_strobe_in && busy && gap_cnt < 5'(idw_pkg::REC_CYC - 1)) begin
                hold <= 1'b1;
            end else if (gap_cnt >= 5'(idw_pkg::REC_CYC - 1)) begin
                hold <= 1'b0;
            end
            dmarq_out <= (start_in ? start_dma_in && cfg.dma_en
                          : dma_xfer && drq_out && !(busy && rd_strobe_in && word_idx == 8'hFF))
                         && !(hold || (rd_strobe_in && gap_cnt < 5'(idw_pkg::REC_CYC - 1)));
        end
    end

    // Registered product keeps the multiplier off the read path
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            capacity <= 32'h0000_0000;
        end else begin
            capacity <= 32'(geom.cyl) * 32'(geom.head) * 32'(geom.spt);
        end
    end

////////////////////////////////////////////////////////////////////////////////

    // AXI4-Lite write path; address and data taken in either order
    assign wr_go = aw_got && w_got && !s_axi_bvalid;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= idw_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[7:2] <= idw_pkg::A_MISC[7:2] && aw_addr != idw_pkg::A_STAT)
                               ? idw_pkg::RESP_OKAY : idw_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Configuration; geometry edits mid-block also change the word now on data_out
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            cfg <= '{dma_en: 1'b0, mult_one: 1'b0, pio_mode: idw_pkg::PIO_RESET};
            geom <= '{cyl: DEF_CYL, head: DEF_HEAD, spt: DEF_SPT};
            card_sectors <= DEF_CARD;
            apm_val <= 16'h0000;
            erase_time <= 16'h0000;
        end else if (wr_go) begin
            case ({aw_addr[7:2], 2'b00})
                idw_pkg::A_CTRL: begin
                    if (w_strb[0]) begin
                        cfg.dma_en <= w_data[idw_pkg::CTRL_DMA];
                        cfg.mult_one <= w_data[idw_pkg::CTRL_MULT];
                        if (w_data[idw_pkg::CTRL_PIO_LSB +: 2] != 2'h3) begin
                            cfg.pio_mode <= w_data[idw_pkg::CTRL_PIO_LSB +: 2];
                        end
                    end
                end
                idw_pkg::A_CYL: begin
                    if (w_strb[0]) geom.cyl[7:0] <= w_data[7:0];
                    if (w_strb[1]) geom.cyl[15:8] <= w_data[15:8];
                end
                idw_pkg::A_HEAD: begin
                    if (w_strb[0]) geom.head[7:0] <= w_data[7:0];
                    if (w_strb[1]) geom.head[15:8] <= w_data[15:8];
                end
                idw_pkg::A_SPT: begin
                    if (w_strb[0]) geom.spt[7:0] <= w_data[7:0];
                    if (w_strb[1]) geom.spt[15:8] <= w_data[15:8];
                end
                idw_pkg::A_CARD: begin
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb[b]) card_sectors[8 * b +: 8] <= w_data[8 * b +: 8];
                    end
                end
                idw_pkg::A_MISC: begin
                    if (w_strb[0]) apm_val[7:0] <= w_data[7:0];
                    if (w_strb[1]) apm_val[15:8] <= w_data[15:8];
                    if (w_strb[2]) erase_time[7:0] <= w_data[23:16];
                    if (w_strb[3]) erase_time[15:8] <= w_data[31:24];
                end
                default: begin
                end
            endcase
        end
    end

    // AXI4-Lite read path, one cycle to answer
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= idw_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= idw_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                idw_pkg::A_CTRL: s_axi_rdata <= {28'h0, cfg.pio_mode, cfg.mult_one, cfg.dma_en};
                idw_pkg::A_CYL: s_axi_rdata <= {16'h0, geom.cyl};
                idw_pkg::A_HEAD: s_axi_rdata <= {16'h0, geom.head};
                idw_pkg::A_SPT: s_axi_rdata <= {16'h0, geom.spt};
                idw_pkg::A_CARD: s_axi_rdata <= card_sectors;
                idw_pkg::A_STAT: s_axi_rdata <= {22'h0, dma_xfer, busy, word_idx};
                idw_pkg::A_MISC: s_axi_rdata <= {erase_time, apm_val};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= idw_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    sequence s_start;
        start_in;
    endsequence
    sequence s_first_word;
        drq_out && word_idx == 8'h00 && data_out == idw_pkg::W_GENCFG;
    endsequence
    property p_start;
        @(posedge core_clk_in) disable iff (!rst_b_in) s_start |=> s_first_word;
    endproperty
    a_start: assert property (p_start) else $error("block did not open at word 0");
    property p_udma;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            drq_out && word_idx == 8'h58 |-> data_out == 16'h0000;
    endproperty
    a_udma: assert property (p_udma) else $error("word 88 not zero");
    property p_rsvd;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            drq_out && (word_idx inside {[8'h5C:8'h9F], [8'hB0:8'hFF]}) |-> data_out == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
    property p_w164;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            drq_out && word_idx == 8'hA4 |-> data_out == idw_pkg::W_ADV164;
    endproperty
    a_w164: assert property (p_w164) else $error("word 164 wrong");
    property p_nodma;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            drq_out && !cfg.dma_en && word_idx == 8'h31 |-> data_out == idw_pkg::W_CAP_DMA;
    endproperty
    a_nodma: assert property (p_nodma) else $error("word 49 wrong without DMA");
    property p_count;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            drq_out && word_idx == 8'h07 && rd_strobe_in |=> data_out == card_sectors[15:0];
    endproperty
    a_count: assert property (p_count) else $error("sector count halves out of order");
    property p_mult;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            drq_out && word_idx == 8'h3B |-> data_out[15:8] == 8'h01 && data_out[7:1] == 7'h00;
    endproperty
    a_mult: assert property (p_mult) else $error("word 59 wrong");
    property p_order;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            busy && rd_strobe_in && !start_in && word_idx != 8'hFF
            |=> word_idx == $past(word_idx) + 8'h01 && drq_out;
    endproperty
    a_order: assert property (p_order) else $error("word order broken");
    property p_pace;
        @(posedge core_clk_in) disable iff (!rst_b_in)
            busy && rd_strobe_in && !start_in && gap_cnt < 5'(idw_pkg::REC_CYC - 1)
            |=> !dmarq_out [*2];
    endproperty
    a_pace: assert property (p_pace) else $error("fast read did not pause request");
endmodule
`default_nettype wire

// [idw_pkg.sv]
// Constants and types for the identify parameter-word source
//
// Function
// - Word 88 (Ultra DMA supported and selected) reads zero
// - Words 92-127, 128-159 and 176-255 read zero
// - Word 164 reads the fixed value 001Bh
// - Without DMA: word 49 is 0100h, words 52, 63, 65 read zero
// - Word 0 reads the fixed configuration code 848Ah
// - Words 7-8 hold the card sector count
// - Serial number is right justified, padded on the left with 20h
// - Model number is left justified, padded on the right with 20h
// - Word 20 reports a dual-ported multi-sector buffer, 0002h
// - Word 21 reports a buffer of two 512-byte sectors
// - Word 48 reports no 32-bit transfers
// - Word 49 shows LBA and DMA (0300h) with DMA on, only the DMA bit (0100h) with DMA off
// - Word 51 reports the highest legacy PIO mode, 0 to 2
// - Word 52 reports no single-word DMA mode
// - Word 53 has bits 0 and 1 set
// - Words 57-58 equal cylinders times heads times sectors per track
// - Word 59 high byte always reads 01h
// - Word 59 low byte resets to 00h, reads 01h after set-multiple
// - Word 64 has bits 0 and 1 set, PIO modes 3 and 4
// - DMA request drops when the host reads faster than the recommended cycle
// - Words 60-61 hold the LBA addressable sector count
// - Words 54-56 hold current cylinders, heads, sectors per track
// - Word 49 bit 8 flags DMA, bit 9 flags LBA
// - Word 7 holds the high half, word 8 the low half
// - Block moves with the single-sector read request handshake
// - Every reserved bit and word reads zero
`default_nettype none
package idw_pkg;
    localparam logic [15:0] W_GENCFG = 16'h848A;
    localparam logic [15:0] W_BUFTYPE = 16'h0002;
    localparam logic [15:0] W_BUFSIZE = 16'h0002;
    localparam logic [15:0] W_ECC = 16'h0004;
    localparam logic [15:0] W_MAXMULT = 16'h0001;
    localparam logic [15:0] W_CAP_LBA = 16'h0200;
    localparam logic [15:0] W_CAP_DMA = 16'h0100;
    localparam logic [15:0] W_VALID = 16'h0003;
    localparam logic [7:0] W_MULT_VALID = 8'h01;
    localparam logic [15:0] W_MWDMA = 16'h0007;
    localparam logic [15:0] W_ADVPIO = 16'h0003;
    localparam logic [15:0] W_CYCLE_NS = 16'h0078;
    localparam logic [15:0] W_FEAT83 = 16'h4004;
    localparam logic [15:0] W_FEAT84 = 16'h4000;
    localparam logic [15:0] W_FEAT86 = 16'h0004;
    localparam logic [15:0] W_FEAT87 = 16'h4000;
    localparam logic [15:0] W_ADV164 = 16'h001B;
    localparam logic [8:0] WORD_COUNT = 9'h100;
    // Register map, byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CYL = 8'h04;
    localparam logic [7:0] A_HEAD = 8'h08;
    localparam logic [7:0] A_SPT = 8'h0C;
    localparam logic [7:0] A_CARD = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_MISC = 8'h18;
    // Control fields
    localparam int CTRL_DMA = 0;
    localparam int CTRL_MULT = 1;
    localparam int CTRL_PIO_LSB = 2;
    localparam logic [1:0] PIO_RESET = 2'h2;
    // Recommended DMA cycle, rounded up to clocks
    localparam int CLK_NS = 8;
    localparam int REC_NS = 120;
    localparam int REC_CYC = (REC_NS + CLK_NS - 1) / CLK_NS;
    typedef struct packed {
        logic dma_en;
        logic mult_one;
        logic [1:0] pio_mode;
    } idw_cfg_s;
    typedef struct packed {
        logic [15:0] cyl;
        logic [15:0] head;
        logic [15:0] spt;
    } idw_geom_s;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [idw_host_model.sv]
// Host-side reader of the identify parameter block
`default_nettype none
module idw_host_model (
    // Clock
    input wire logic clk_in,
    // From the block
    input wire logic drq_in,
    input wire logic dmarq_in,
    input wire logic [15:0] data_in,
    // To the block
    output logic start_out,
    output logic start_dma_out,
    output logic rd_strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] words [256];
    int dma_lo = 0;
    int dma_hi = 0;
    logic busy = 1'b0;
    initial begin
        start_out = 1'b0;
        start_dma_out = 1'b0;
        rd_strobe_out = 1'b0;
    end
    ////////////////////////////////////////
    // Pacing seen while the block is read
    always @(posedge clk_in) begin
        if (busy && drq_in && dmarq_in) dma_hi++;
        if (busy && drq_in && !dmarq_in) dma_lo++;
    end
    // Gap stretches each read cycle, so pacing is tried fast and slow
    task automatic run(input logic dma, input int gap);
        dma_lo = 0;
        dma_hi = 0;
        @(posedge clk_in);
        start_out <= 1'b1;
        start_dma_out <= dma;
        busy = 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
        for (int i = 0; i < 256; i++) begin
            repeat (gap) @(posedge clk_in);
            @(posedge clk_in);
            words[i] = data_in;
            rd_strobe_out <= 1'b1;
            @(posedge clk_in);
            rd_strobe_out <= 1'b0;
        end
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// [idw_source_tb_top.sv]
// Self-checking bench for the identify parameter-word source
`default_nettype none
module idw_source_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start, start_dma, rd_strobe, drq, dmarq, awready, wready, bvalid, arready, rvalid;
    logic [15:0] data;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int miscompares = 0;
    int cmp_count = 0;
    initial begin
        forever #4 clk = ~clk;
    end
    idw_source #(.DEF_CYL(16'h0200), .DEF_HEAD(16'h0010), .DEF_SPT(16'h0020),
        .DEF_CARD(32'h0001_2345)) u_dut (
        .core_clk_in(clk), .rst_b_in(rst_b), .start_in(start), .start_dma_in(start_dma),
        .rd_strobe_in(rd_strobe), .drq_out(drq), .dmarq_out(dmarq), .data_out(data),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    idw_host_model u_host (.clk_in(clk), .drq_in(drq), .dmarq_in(dmarq), .data_in(data),
        .start_out(start), .start_dma_out(start_dma), .rd_strobe_out(rd_strobe));
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chw(input int i, input logic [15:0] e);
        chk($sformatf("word %0d", i), {16'h0000, e}, {16'h0000, u_host.words[i]});
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    // Bus waits are bounded; an expired wait ends the run
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        miscompares++;
        report_and_stop();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                resp = rresp;
                rd = rdata;
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        report_and_stop();
    endtask
    ////////////////////////////////////////
    // DMA asked while disabled: plain PIO read of the default block
    task automatic sc_defaults();
        u_host.run(1'b1, 0);
        chk("dmarq", 32'h0, 32'(u_host.dma_hi));
        chw(0, 16'h848A);
        chw(7, 16'h0001);
        chw(8, 16'h2345);
        chw(14, 16'h2020);
        chw(15, 16'h2030);
        chw(19, 16'h3031);
        chw(20, 16'h0002);
        chw(21, 16'h0002);
        chw(27, 16'h4745);
        chw(35, 16'h5244);
        chw(46, 16'h2020);
        chw(48, 16'h0000);
        chw(49, 16'h0100);
        chw(52, 16'h0000);
        chw(53, 16'h0003);
        chw(57, 16'h0000);
        chw(58, 16'h0004);
        chw(59, 16'h0100);
        chw(60, 16'h2345);
        chw(61, 16'h0001);
        chw(63, 16'h0000);
        chw(64, 16'h0003);
        chw(65, 16'h0000);
        chw(88, 16'h0000);
        chw(164, 16'h001B);
        for (int i = 92; i < 256; i++) begin
            if (i < 160 || i > 175) chw(i, 16'h0000);
        end
    endtask
    // New geometry and DMA on, read slowly enough to need no pacing
    task automatic sc_config();
        axi_wr(idw_pkg::A_CTRL, 32'h0000_000B);
        chk("bresp", {30'h0, idw_pkg::RESP_OKAY}, {30'h0, resp});
        axi_wr(idw_pkg::A_CYL, 32'h0000_0003);
        axi_wr(idw_pkg::A_HEAD, 32'h0000_0005);
        axi_wr(idw_pkg::A_SPT, 32'h0000_0007);
        u_host.run(1'b1, 14);
        chk("slow pacing", 32'h0, 32'(u_host.dma_lo));
        chw(49, 16'h0300);
        chw(54, 16'h0003);
        chw(55, 16'h0005);
        chw(56, 16'h0007);
        chw(57, 16'h0069);
        chw(59, 16'h0101);
    endtask
    // Back-to-back host reads under DMA must be paced
    task automatic sc_pacing();
        u_host.run(1'b1, 0);
        chk("fast pacing", 32'h1, {31'h0, u_host.dma_lo > 0});
        chw(0, 16'h848A);
        chw(255, 16'h0000);
    endtask
    task automatic sc_bus_errors();
        axi_rd(8'h40);
        chk("unmapped resp", {30'h0, idw_pkg::RESP_SLVERR}, {30'h0, resp});
        chk("unmapped data", 32'h0000_0000, rd);
        axi_wr(idw_pkg::A_STAT, 32'h0000_00FF);
        chk("stat resp", {30'h0, idw_pkg::RESP_SLVERR}, {30'h0, resp});
        axi_rd(idw_pkg::A_CTRL);
        chk("ctrl", 32'h0000_000B, rd);
    endtask
    // Reset lands mid-block; defaults must return
    task automatic sc_reset_mid();
        fork
            u_host.run(1'b0, 0);
            begin
                repeat (60) @(posedge clk);
                do_reset();
            end
        join
        chk("drq", 32'h0, {31'h0, drq});
        u_host.run(1'b0, 0);
        chw(49, 16'h0100);
        chw(51, 16'h0200);
        chw(54, 16'h0200);
        chw(59, 16'h0100);
    endtask
    initial begin
        do_reset();
        sc_defaults();
        sc_config();
        sc_pacing();
        sc_bus_errors();
        sc_reset_mid();
        report_and_stop();
    end
endmodule
`default_nettype wire
